// ### verilog/temp_threshold_alert_regs.sv
// result and limit registers with consecutive-fault alert logic
module temp_threshold_alert_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // configuration from the configuration register
  input wire temp_alert_pkg::alert_cfg_t cfg_i,
  input wire logic sleep_set_i,  // pulse: config write with sleep select one
  // conversion results
  input wire temp_alert_pkg::conv_sample_t conv_i,
  // byte access from the serial slave
  input wire logic start_i,  // pulse: new transfer, byte phase back to msb
  input wire logic idx_wr_i,  // pulse: index pointer byte received
  input wire logic wr_byte_i,  // pulse: data byte received
  input wire logic [7:0] wr_data_i,
  input wire logic rd_byte_i,  // pulse: slave needs the next byte
  output logic [7:0] rd_data_o,
  // alert pin level and internal active state
  output logic alert_o,
  output logic alert_active_o
);
  import temp_alert_pkg::*;

  logic [7:0] index_q;
  logic phase_q;  // 0 expects msb byte, 1 expects lsb byte
  logic [7:0] wr_hi_q;
  logic [7:0] rd_lo_q;
  logic [15:0] result_q;
  logic [15:0] lower_q;
  logic [15:0] upper_q;
  logic [15:0] rd_word;
  await_t await_q;
  logic active_q;
  logic [1:0] cnt_q;
  logic mode_seen_q;
  logic qualify;
  logic hit;
  logic read_clr;

  // index pointer keeps its value so repeated reads hit the same register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      index_q <= IDX_TEMPERATURE_RESULT;
    end else if (idx_wr_i) begin
      index_q <= wr_data_i;
    end
  end

  // byte phase: msb first for both reads and writes
  always_ff @(posedge clk_i) begin
    if (srst_i || start_i || idx_wr_i) begin
      phase_q <= 1'b0;
    end else if (wr_byte_i || rd_byte_i) begin
      phase_q <= ~phase_q;
    end
  end

  // msb byte parked until the lsb arrives so a limit never updates half way
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_hi_q <= 8'h00;
    end else if (wr_byte_i && !phase_q) begin
      wr_hi_q <= wr_data_i;
    end
  end

  // limit registers, committed on the lsb byte, low nibble forced to zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lower_q <= LOWER_LIMIT_RST;
      upper_q <= UPPER_LIMIT_RST;
    end else if (wr_byte_i && phase_q) begin
      if (index_q == IDX_LOWER_LIMIT) begin
        lower_q <= {wr_hi_q, wr_data_i} & LIMIT_RW_MASK;
      end
      if (index_q == IDX_UPPER_LIMIT) begin
        upper_q <= {wr_hi_q, wr_data_i} & LIMIT_RW_MASK;
      end
    end
  end

  // result only follows conversions; bus writes to it are not decoded here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_q <= TEMPERATURE_RESULT_RST;
    end else if (conv_i.valid) begin
      result_q <= conv_i.value;
    end
  end

  // read mux; unowned indexes return a fixed byte
  always_comb begin
    unique case (index_q)
      IDX_TEMPERATURE_RESULT: rd_word = result_q;
      IDX_LOWER_LIMIT: rd_word = lower_q;
      IDX_UPPER_LIMIT: rd_word = upper_q;
      default: rd_word = {UNMAPPED_BYTE, UNMAPPED_BYTE};
    endcase
  end

  // the lsb is snapped with the msb so a conversion between the two reads
  // cannot tear the word
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o <= 8'h00;
      rd_lo_q <= 8'h00;
    end else if (rd_byte_i) begin
      if (!phase_q) begin
        rd_data_o <= rd_word[15:8];
        rd_lo_q <= rd_word[7:0];
      end else begin
        rd_data_o <= rd_lo_q;
      end
    end
  end

  // limit condition awaited right now, signed compares
  always_comb begin
    if (await_q == WAIT_HIGH) begin
      qualify = $signed(conv_i.value) >= $signed(upper_q);
    end else if (cfg_i.irq_behaviour_select) begin
      qualify = $signed(conv_i.value) < $signed(lower_q);
    end else begin
      qualify = $signed(conv_i.value) <= $signed(lower_q);
    end
  end

  assign hit = conv_i.valid && qualify && (cnt_q == cfg_i.fault_count_select);
  assign read_clr = rd_byte_i && cfg_i.irq_behaviour_select;

  // mode tracker: a change of mode restarts the filter from a clean state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_seen_q <= 1'b0;
    end else begin
      mode_seen_q <= cfg_i.irq_behaviour_select;
    end
  end

  // consecutive-fault counter
  always_ff @(posedge clk_i) begin
    if (srst_i || (mode_seen_q != cfg_i.irq_behaviour_select)) begin
      cnt_q <= 2'h0;
    end else if (conv_i.valid) begin
      if (!qualify || hit) begin
        cnt_q <= 2'h0;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end

  // awaited condition alternates high/low in both modes
  always_ff @(posedge clk_i) begin
    if (srst_i || (mode_seen_q != cfg_i.irq_behaviour_select)) begin
      await_q <= WAIT_HIGH;
    end else if (hit) begin
      await_q <= (await_q == WAIT_HIGH) ? WAIT_LOW : WAIT_HIGH;
    end
  end

  // active flag; in interrupt mode a new event beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (srst_i || (mode_seen_q != cfg_i.irq_behaviour_select)) begin
      active_q <= 1'b0;
    end else if (!cfg_i.irq_behaviour_select) begin
      if (hit) begin
        active_q <= (await_q == WAIT_HIGH);
      end
    end else if (hit) begin
      active_q <= 1'b1;
    end else if (read_clr || sleep_set_i) begin
      active_q <= 1'b0;
    end
  end

  // pin level: one cycle behind the active flag, kept registered for the pad
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      alert_o <= 1'b1;
      alert_active_o <= 1'b0;
    end else begin
      alert_o <= cfg_i.output_polarity ? active_q : ~active_q;
      alert_active_o <= active_q;
    end
  end

  // checks
  upper_trip_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && await_q == WAIT_HIGH
     && conv_i.valid && $signed(conv_i.value) >= $signed(upper_q) && cnt_q == cfg_i.fault_count_select)
    |=> active_q)
    else $error("comparator alert did not assert at upper limit");

  lower_release_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && await_q == WAIT_LOW
     && conv_i.valid && $signed(conv_i.value) <= $signed(lower_q) && cnt_q == cfg_i.fault_count_select)
    |=> !active_q)
    else $error("comparator alert did not release at lower limit");

  comp_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (!cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && !conv_i.valid)
    |=> $stable(active_q))
    else $error("comparator alert changed without a conversion");

  irq_read_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && rd_byte_i && !hit)
    |=> !active_q)
    else $error("register read did not clear interrupt alert");

  sleep_clr_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && sleep_set_i && !hit)
    |=> !active_q)
    else $error("sleep select did not clear interrupt alert");

  irq_rearm_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && await_q == WAIT_LOW
     && conv_i.valid && $signed(conv_i.value) >= $signed(lower_q))
    |=> cnt_q == 2'h0)
    else $error("interrupt low event counted at or above lower limit");

  // a new event must win over a read or sleep clear in the same cycle
  irq_set_wins_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (cfg_i.irq_behaviour_select && $stable(cfg_i.irq_behaviour_select) && hit)
    |=> active_q)
    else $error("interrupt event did not set the alert");

  limit_nibble_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (lower_q[3:0] == 4'h0) && (upper_q[3:0] == 4'h0))
    else $error("limit low nibble not zero");

  result_ro_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !conv_i.valid |=> $stable(result_q))
    else $error("result changed without a conversion");

  msb_first_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rd_byte_i && !phase_q && !start_i && !idx_wr_i) ##1 (rd_byte_i && !start_i && !idx_wr_i)
    |=> rd_data_o == $past(rd_word[7:0], 2))
    else $error("second read byte is not the low byte of the word");

  polarity_a: assert property (@(posedge clk_i) disable iff (srst_i)
    !$past(srst_i) |-> alert_o == ($past(cfg_i.output_polarity) ? $past(active_q) : !$past(active_q)))
    else $error("alert pin level does not follow polarity");

endmodule : temp_threshold_alert_regs

// ### verilog/temp_alert_pkg.sv
// shared constants and carrier types for the temperature limit and alert block
package temp_alert_pkg;

  // register indexes as seen through the index pointer
  localparam logic [7:0] IDX_TEMPERATURE_RESULT = 8'h00;
  localparam logic [7:0] IDX_LOWER_LIMIT = 8'h02;
  localparam logic [7:0] IDX_UPPER_LIMIT = 8'h03;

  // reset values: 75 degC and 80 degC at 1/128 degC per lsb, result reads zero
  localparam logic [15:0] LOWER_LIMIT_RST = 16'h2580;
  localparam logic [15:0] UPPER_LIMIT_RST = 16'h2800;
  localparam logic [15:0] TEMPERATURE_RESULT_RST = 16'h0000;

  // limit registers hold bits 15..4, bits 3..0 always read zero
  localparam logic [15:0] LIMIT_RW_MASK = 16'hfff0;

  // value driven for indexes this block does not own
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  // configuration bits handed in by the configuration register owner
  typedef struct packed {
    logic irq_behaviour_select;  // 0 comparator, 1 interrupt
    logic output_polarity;       // 0 active low, 1 active high
    logic [1:0] fault_count_select;  // 00..11 -> 1..4 conversions
  } alert_cfg_t;

  // one finished conversion
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } conv_sample_t;

  // which limit condition the fault filter is waiting for
  typedef enum logic {
    WAIT_HIGH,
    WAIT_LOW
  } await_t;

endpackage : temp_alert_pkg

// ### verif/bus_master_model.sv
// two-wire master model issuing byte-level register transfers
module bus_master_model (
  // clock
  input wire logic clk_i,
  // byte access toward the device
  output logic start_o,
  output logic idx_wr_o,
  output logic wr_byte_o,
  output logic [7:0] wr_data_o,
  output logic rd_byte_o,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle master: nothing requested
  initial begin
    start_o = 1'b0;
    idx_wr_o = 1'b0;
    wr_byte_o = 1'b0;
    wr_data_o = 8'h00;
    rd_byte_o = 1'b0;
  end

  // start condition, then the index pointer byte
  task automatic sel(input logic [7:0] idx);
    @(posedge clk_i);
    #1 start_o = 1'b1;
    @(posedge clk_i);
    #1 start_o = 1'b0;
    idx_wr_o = 1'b1;
    wr_data_o = idx;
    @(posedge clk_i);
    #1 idx_wr_o = 1'b0;
  endtask : sel

  // word write, upper byte first
  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    sel(idx);
    wr_byte_o = 1'b1;
    wr_data_o = v[15:8];
    @(posedge clk_i);
    #1 wr_data_o = v[7:0];
    @(posedge clk_i);
    // released byte lane shows a stale inverted value, never the last one
    #1 wr_byte_o = 1'b0;
    wr_data_o = ~v[7:0];
  endtask : wr

  // word read: two back-to-back byte requests, msb arrives first
  task automatic rd(input logic [7:0] idx, output logic [15:0] v);
    sel(idx);
    rd_byte_o = 1'b1;
    @(posedge clk_i);
    #1 v[15:8] = rd_data_i;
    @(posedge clk_i);
    #1 rd_byte_o = 1'b0;
    v[7:0] = rd_data_i;
  endtask : rd
endmodule : bus_master_model

// ### verif/temp_threshold_alert_regs_tb_top.sv
// testbench for the result, limit and alert logic
module temp_threshold_alert_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import temp_alert_pkg::*;

  logic clk_i;
  logic srst_i;
  alert_cfg_t cfg;
  logic sleep;
  conv_sample_t conv;
  logic start, idx_wr, wr_byte, rd_byte;
  logic [7:0] wr_data, rd_data;
  logic alert, act;
  logic [15:0] v;
  int error_cnt;
  int samples_checked;

  temp_threshold_alert_regs i_temp_threshold_alert_regs (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg), .sleep_set_i(sleep), .conv_i(conv),
    .start_i(start), .idx_wr_i(idx_wr), .wr_byte_i(wr_byte), .wr_data_i(wr_data),
    .rd_byte_i(rd_byte), .rd_data_o(rd_data), .alert_o(alert), .alert_active_o(act)
  );

  bus_master_model i_bus_master_model (
    .clk_i(clk_i), .start_o(start), .idx_wr_o(idx_wr), .wr_byte_o(wr_byte),
    .wr_data_o(wr_data), .rd_byte_o(rd_byte), .rd_data_i(rd_data)
  );

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // alert state and pin level under the present polarity
  task automatic al(input logic a);
    chk({15'h0, act}, {15'h0, a});
    chk({15'h0, alert}, {15'h0, a ~^ cfg.output_polarity});
  endtask : al

  // one conversion, then the two-cycle alert latency
  task automatic cv(input logic [15:0] t);
    @(posedge clk_i);
    #1 conv = '{1'b1, t};
    @(posedge clk_i);
    #1 conv = '{1'b0, ~t};
    tick(2);
  endtask : cv

  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    srst_i = 1'b1;
    sleep = 1'b0;
    conv = '0;
    cfg = '{1'b0, 1'b0, 2'b01};
    tick(2);
    srst_i = 1'b0;
    al(1'b0);
    i_bus_master_model.rd(IDX_LOWER_LIMIT, v);
    chk(v, 16'h2580);
    i_bus_master_model.rd(IDX_UPPER_LIMIT, v);
    chk(v, 16'h2800);
    i_bus_master_model.rd(IDX_TEMPERATURE_RESULT, v);
    chk(v, 16'h0000);
    i_bus_master_model.wr(IDX_UPPER_LIMIT, 16'h2a3f);
    i_bus_master_model.rd(IDX_UPPER_LIMIT, v);
    chk(v, 16'h2a30);
    i_bus_master_model.wr(IDX_UPPER_LIMIT, 16'h2800);
    i_bus_master_model.wr(IDX_TEMPERATURE_RESULT, 16'h1234);
    i_bus_master_model.rd(IDX_TEMPERATURE_RESULT, v);
    chk(v, 16'h0000);
    // comparator, two conversions, active high; a miss restarts the count
    cfg.output_polarity = 1'b1;
    cv(16'h2800);
    al(1'b0);
    cv(16'h27ff);
    cv(16'h2800);
    al(1'b0);
    cv(16'h3200);
    al(1'b1);
    i_bus_master_model.rd(IDX_TEMPERATURE_RESULT, v);
    chk(v, 16'h3200);
    cv(16'h2580);
    al(1'b1);
    cv(16'hec00);
    al(1'b0);
    // interrupt mode, single conversion, active low
    cfg = '{1'b1, 1'b0, 2'b00};
    cv(16'h2800);
    al(1'b1);
    i_bus_master_model.rd(IDX_LOWER_LIMIT, v);
    tick(2);
    al(1'b0);
    cv(16'h3200);
    al(1'b0);
    cv(16'h2580);
    al(1'b0);
    cv(16'h257f);
    al(1'b1);
    @(posedge clk_i);
    #1 sleep = 1'b1;
    @(posedge clk_i);
    #1 sleep = 1'b0;
    tick(2);
    al(1'b0);
    cv(16'h2800);
    al(1'b1);
    cfg.irq_behaviour_select = 1'b0;
    tick(2);
    al(1'b0);
    // remaining fault counts: three and four conversions
    for (int n = 3; n <= 4; n++) begin
      cfg = '{1'b0, 1'b1, 2'(n - 1)};
      repeat (n - 1) cv(16'h2800);
      al(1'b0);
      cv(16'h2800);
      al(1'b1);
      repeat (n) cv(16'hec00);
      al(1'b0);
    end
    // lower limit nibble, then a mid-run reset must restore power-up contents
    i_bus_master_model.wr(IDX_LOWER_LIMIT, 16'h1237);
    i_bus_master_model.rd(IDX_LOWER_LIMIT, v);
    chk(v, 16'h1230);
    srst_i = 1'b1;
    tick(2);
    srst_i = 1'b0;
    i_bus_master_model.rd(IDX_LOWER_LIMIT, v);
    chk(v, 16'h2580);
    i_bus_master_model.rd(IDX_TEMPERATURE_RESULT, v);
    chk(v, 16'h0000);
    al(1'b0);
    conclude();
  end
endmodule : temp_threshold_alert_regs_tb_top
